// File: rtl/dsmsel_top.sv
/*
  Modulator source and carrier select with mixing, sync and APB registers.
  Assumes an APB master on pclk, peripheral levels from other logic and
  pins arriving asynchronously; pins and peripheral outputs are resynchronised here, the PWM and SPI mode flags are not.
*/
// The APB slave port and the register addresses were left to the implementer.
module dsmsel_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        modulation_input_pin,
  input  wire logic        carrier_input_pin_1,
  input  wire logic        carrier_input_pin_2,
  input  wire logic        refclk_out,
  input  wire logic [3:0]  ccp_out,
  input  wire logic [3:0]  ccp_pwm_mode,
  input  wire logic [1:0]  cmp_out,
  input  wire logic [1:0]  sdo_out,
  input  wire logic [1:0]  spi_mode,
  input  wire logic        uart_tx,
  output logic [9:0]       periph_pin_disable,
  output logic             modulated_out,
  output logic             slew_limit_enable
);
  typedef struct packed {
    logic        en;
    logic        oe;
    logic        slr;
    logic        opol;
    logic        soft_bit;
    logic        src_dis;
    logic [3:0]  src_code;
    logic        ch_dis;
    logic        ch_inv;
    logic        ch_sync;
    logic [3:0]  ch_code;
    logic        cl_dis;
    logic        cl_inv;
    logic        cl_sync;
    logic [3:0]  cl_code;
    logic        sel_high;
    logic        carh_prev;
    logic        carl_prev;
    logic        mix;
    logic        pin_out;
    logic [31:0] rdata;
  } dsmsel_state_t;

  dsmsel_state_t st;
  dsmsel_state_t next_st;

  logic [dsmsel_pkg::S_WIDTH-1:0] raw_in;
  logic [dsmsel_pkg::S_WIDTH-1:0] sin;
  logic                           carh;
  logic                           carl;
  logic [4:0]                     dis_h;
  logic [4:0]                     dis_l;
  logic                           mod_sig;
  logic [dsmsel_pkg::P_COUNT-1:0] dis_src;
  logic [3:0]                     src_unit;
  logic                           fall_h;
  logic                           fall_l;
  logic                           addr_ok;
  logic                           wr_access;
  logic                           rd_setup;
  logic [7:0]                     rd_byte;

  assign raw_in = {uart_tx, sdo_out, cmp_out, ccp_out, refclk_out,
                   carrier_input_pin_2, carrier_input_pin_1, modulation_input_pin};

  dsmsel_sync #(
    .WIDTH (dsmsel_pkg::S_WIDTH)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (raw_in),
    .sync_out (sin)
  );

  dsmsel_carrier_mux u_carh (
    .enable      (st.en),
    .code        (st.ch_code),
    .invert      (st.ch_inv),
    .pin_disable (st.ch_dis),
    .cin1        (sin[dsmsel_pkg::S_CIN1]),
    .cin2        (sin[dsmsel_pkg::S_CIN2]),
    .refclk      (sin[dsmsel_pkg::S_REFCLK]),
    .ccp         (sin[dsmsel_pkg::S_CCP1+:4]),
    .pwm_mode    (ccp_pwm_mode),
    .carrier     (carh),
    .periph_dis  (dis_h)
  );

  dsmsel_carrier_mux u_carl (
    .enable      (st.en),
    .code        (st.cl_code),
    .invert      (st.cl_inv),
    .pin_disable (st.cl_dis),
    .cin1        (sin[dsmsel_pkg::S_CIN1]),
    .cin2        (sin[dsmsel_pkg::S_CIN2]),
    .refclk      (sin[dsmsel_pkg::S_REFCLK]),
    .ccp         (sin[dsmsel_pkg::S_CCP1+:4]),
    .pwm_mode    (ccp_pwm_mode),
    .carrier     (carl),
    .periph_dis  (dis_l)
  );

  // Modulation source select and its pin-disable decode
  always_comb begin
    src_unit = st.src_code - dsmsel_pkg::SRC_CCP1;
    mod_sig  = 1'b0;
    dis_src  = '0;
    if (!st.en) begin
      mod_sig = st.soft_bit;                                   // RL16
    end else if (st.src_code == dsmsel_pkg::SRC_SOFT) begin
      mod_sig = st.soft_bit;                                   // RL2
    end else if (st.src_code == dsmsel_pkg::SRC_PIN) begin
      mod_sig = sin[dsmsel_pkg::S_MODPIN];                     // RL2
    end else if (st.src_code <= dsmsel_pkg::SRC_CCP4) begin
      mod_sig = sin[dsmsel_pkg::S_CCP1 + src_unit[1:0]] & ccp_pwm_mode[src_unit[1:0]];  // RL3
      dis_src[dsmsel_pkg::P_CCP1 + src_unit[1:0]] = st.src_dis;                        // RL1
    end else if (st.src_code == dsmsel_pkg::SRC_CMP1 || st.src_code == dsmsel_pkg::SRC_CMP2) begin
      mod_sig = sin[dsmsel_pkg::S_CMP1 + st.src_code[0]];     // RL4
      dis_src[dsmsel_pkg::P_CMP1 + st.src_code[0]] = st.src_dis;   // RL1
    end else if (st.src_code == dsmsel_pkg::SRC_SDO1 || st.src_code == dsmsel_pkg::SRC_SDO2) begin
      // Serial data only counts while its port runs in SPI mode
      mod_sig = sin[dsmsel_pkg::S_SDO1 + st.src_code[0]] & spi_mode[st.src_code[0]];   // RL4
      dis_src[dsmsel_pkg::P_SDO1 + st.src_code[0]] = st.src_dis;   // RL1
    end else if (st.src_code == dsmsel_pkg::SRC_UART) begin
      mod_sig = sin[dsmsel_pkg::S_UART];                       // RL4
      dis_src[dsmsel_pkg::P_UART] = st.src_dis;                // RL1
    end else begin
      mod_sig = 1'b0;                                          // RL5
    end
  end

  assign fall_h = st.carh_prev & ~carh;
  assign fall_l = st.carl_prev & ~carl;

  assign addr_ok   = (paddr == dsmsel_pkg::ADDR_CTRL) || (paddr == dsmsel_pkg::ADDR_SRC) ||
                     (paddr == dsmsel_pkg::ADDR_CARH) || (paddr == dsmsel_pkg::ADDR_CARL);
  assign wr_access = psel && penable && pwrite && addr_ok;
  assign rd_setup  = psel && !penable && !pwrite;

  // Read view; unimplemented bits are simply never stored
  always_comb begin
    rd_byte = 8'h00;
    if (paddr == dsmsel_pkg::ADDR_CTRL) begin
      rd_byte[dsmsel_pkg::CTRL_EN]   = st.en;
      rd_byte[dsmsel_pkg::CTRL_OE]   = st.oe;
      rd_byte[dsmsel_pkg::CTRL_SLR]  = st.slr;
      rd_byte[dsmsel_pkg::CTRL_OPOL] = st.opol;
      rd_byte[dsmsel_pkg::CTRL_OUT]  = st.mix ^ st.opol;
      rd_byte[dsmsel_pkg::CTRL_BIT]  = st.soft_bit;
    end else if (paddr == dsmsel_pkg::ADDR_SRC) begin
      rd_byte[dsmsel_pkg::SEL_DIS]      = st.src_dis;               // RL13
      rd_byte[dsmsel_pkg::CODE_MSB:0]   = st.src_code;
    end else if (paddr == dsmsel_pkg::ADDR_CARH) begin
      rd_byte[dsmsel_pkg::SEL_DIS]      = st.ch_dis;
      rd_byte[dsmsel_pkg::CAR_INV]      = st.ch_inv;
      rd_byte[dsmsel_pkg::CAR_SYNC]     = st.ch_sync;
      rd_byte[dsmsel_pkg::CODE_MSB:0]   = st.ch_code;               // RL13
    end else if (paddr == dsmsel_pkg::ADDR_CARL) begin
      rd_byte[dsmsel_pkg::SEL_DIS]      = st.cl_dis;
      rd_byte[dsmsel_pkg::CAR_INV]      = st.cl_inv;
      rd_byte[dsmsel_pkg::CAR_SYNC]     = st.cl_sync;
      rd_byte[dsmsel_pkg::CODE_MSB:0]   = st.cl_code;
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_comb begin
    next_st = st;
    if (rd_setup) begin
      next_st.rdata = {24'h000000, rd_byte};
    end
    if (wr_access) begin
      if (paddr == dsmsel_pkg::ADDR_CTRL) begin
        next_st.en       = pwdata[dsmsel_pkg::CTRL_EN];
        next_st.oe       = pwdata[dsmsel_pkg::CTRL_OE];
        next_st.slr      = pwdata[dsmsel_pkg::CTRL_SLR];
        next_st.opol     = pwdata[dsmsel_pkg::CTRL_OPOL];
        next_st.soft_bit = pwdata[dsmsel_pkg::CTRL_BIT];
      end else if (paddr == dsmsel_pkg::ADDR_SRC) begin
        next_st.src_dis  = pwdata[dsmsel_pkg::SEL_DIS];
        next_st.src_code = pwdata[dsmsel_pkg::CODE_MSB:0];     // RL13
      end else if (paddr == dsmsel_pkg::ADDR_CARH) begin
        next_st.ch_dis   = pwdata[dsmsel_pkg::SEL_DIS];
        next_st.ch_inv   = pwdata[dsmsel_pkg::CAR_INV];
        next_st.ch_sync  = pwdata[dsmsel_pkg::CAR_SYNC];
        next_st.ch_code  = pwdata[dsmsel_pkg::CODE_MSB:0];
      end else begin
        next_st.cl_dis   = pwdata[dsmsel_pkg::SEL_DIS];
        next_st.cl_inv   = pwdata[dsmsel_pkg::CAR_INV];
        next_st.cl_sync  = pwdata[dsmsel_pkg::CAR_SYNC];
        next_st.cl_code  = pwdata[dsmsel_pkg::CODE_MSB:0];
      end
    end

    // Carrier choice follows the modulator, held back by sync options
    if (st.sel_high && !mod_sig) begin
      if (!st.ch_sync || fall_h) begin        // RL8 RL9
        next_st.sel_high = 1'b0;
      end
    end else if (!st.sel_high && mod_sig) begin
      if (!st.cl_sync || fall_l) begin        // RL17 RL9
        next_st.sel_high = 1'b1;
      end
    end
    next_st.carh_prev = carh;
    next_st.carl_prev = carl;
    next_st.mix       = next_st.sel_high ? carh : carl;          // RL15 RL19
    // Pin stays low when disabled or output enable is clear
    next_st.pin_out   = (next_st.en && next_st.oe) ? (next_st.mix ^ next_st.opol) : 1'b0;  // RL18
  end

  // Selection registers start at zero here; no separate warm reset exists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;                                       // RL14
      st.slr      <= dsmsel_pkg::CTRL_RESET[dsmsel_pkg::CTRL_SLR];
    end else begin
      st <= next_st;
    end
  end

  assign prdata             = st.rdata;
  assign pready             = 1'b1;
  assign pslverr            = psel && penable && !addr_ok;
  assign modulated_out      = st.pin_out;
  assign slew_limit_enable  = st.slr;
  assign periph_pin_disable = dis_src |
                              {dis_h[4] | dis_l[4], 5'h00, dis_h[3:0] | dis_l[3:0]};

  a_src_disable_pin: assert property (  // RL1
    @(posedge pclk) disable iff (!presetn)
    (st.src_dis && st.src_code == dsmsel_pkg::SRC_UART && st.en) |-> periph_pin_disable[dsmsel_pkg::P_UART])
    else $error("source pin drive not disabled");

  a_src_pwm_gate: assert property (  // RL3
    @(posedge pclk) disable iff (!presetn)
    (st.en && st.src_code == dsmsel_pkg::SRC_CCP1 && !ccp_pwm_mode[0]) |-> !mod_sig)
    else $error("non-PWM unit passed as modulation source");

  a_src_reserved: assert property (  // RL5
    @(posedge pclk) disable iff (!presetn)
    (st.en && st.src_code > dsmsel_pkg::SRC_UART) |-> !mod_sig)
    else $error("reserved source code connected a signal");

  a_carh_invert: assert property (  // RL7
    @(posedge pclk) disable iff (!presetn)
    (st.en && st.ch_code == dsmsel_pkg::CAR_PIN1) |-> carh == (sin[dsmsel_pkg::S_CIN1] ^ st.ch_inv))
    else $error("high carrier polarity wrong");

  a_hsync_hold: assert property (  // RL8
    @(posedge pclk) disable iff (!presetn)
    (st.ch_sync && st.sel_high && !mod_sig && !fall_h) |=> st.sel_high)
    else $error("high carrier left before falling edge");

  a_nosync_switch: assert property (  // RL9
    @(posedge pclk) disable iff (!presetn)
    (!st.ch_sync && st.sel_high && !mod_sig) |=> !st.sel_high)
    else $error("unsynchronised switch delayed");

  a_lsync_hold: assert property (  // RL17
    @(posedge pclk) disable iff (!presetn)
    (st.cl_sync && !st.sel_high && mod_sig && !fall_l) |=> !st.sel_high)
    else $error("low carrier left before falling edge");

  a_mix_follow: assert property (  // RL15
    @(posedge pclk) disable iff (!presetn)
    ##1 st.mix == (st.sel_high ? $past(carh) : $past(carl)))
    else $error("mixed carrier does not match selection");

  a_disable_force: assert property (  // RL16
    @(posedge pclk) disable iff (!presetn)
    !st.en |-> (!carh && !carl && mod_sig == st.soft_bit))
    else $error("disabled module not forced to ground");

  a_unused_zero: assert property (  // RL13
    @(posedge pclk) disable iff (!presetn)
    (rd_setup && paddr == dsmsel_pkg::ADDR_SRC) |=> prdata[6:4] == 3'h0)
    else $error("unused source bits read nonzero");

  a_out_polarity: assert property (  // RL18
    @(posedge pclk) disable iff (!presetn)
    ##1 (st.en && st.oe) |-> modulated_out == (st.mix ^ st.opol))
    else $error("output polarity wrong");

  a_carh_ground: assert property (  // RL10
    @(posedge pclk) disable iff (!presetn)
    (st.en && st.ch_code == dsmsel_pkg::CAR_GND) |-> carh == st.ch_inv)
    else $error("ground carrier not constant");

  a_carh_reserved: assert property (  // RL12
    @(posedge pclk) disable iff (!presetn)
    (st.en && st.ch_code > dsmsel_pkg::CAR_CCP4) |-> carh == st.ch_inv)
    else $error("reserved carrier code connected a signal");

  a_sdo_gate: assert property (  // RL4
    @(posedge pclk) disable iff (!presetn)
    (st.en && st.src_code == dsmsel_pkg::SRC_SDO1 && !spi_mode[0]) |-> !mod_sig)
    else $error("serial data passed outside SPI mode");

  a_refclk_disable: assert property (  // RL6
    @(posedge pclk) disable iff (!presetn)
    (st.ch_dis && st.ch_code == dsmsel_pkg::CAR_REFCLK) |-> periph_pin_disable[dsmsel_pkg::P_REFCLK])
    else $error("reference clock pin drive not disabled");

  a_dis_idle: assert property (  // RL1 RL6
    @(posedge pclk) disable iff (!presetn)
    (!st.src_dis && !st.ch_dis && !st.cl_dis) |-> periph_pin_disable == '0)
    else $error("pin drive disabled with no disable bit");

  a_soft_source: assert property (  // RL2
    @(posedge pclk) disable iff (!presetn)
    (st.en && st.src_code == dsmsel_pkg::SRC_SOFT) |-> mod_sig == st.soft_bit)
    else $error("soft bit not used as modulation source");

  a_sync_delay: assert property (  // RL20
    @(posedge pclk) disable iff (!presetn)
    ##2 sin == $past(raw_in, 2))
    else $error("inputs not delayed by two flops");

  a_pin_idle_low: assert property (  // RL16
    @(posedge pclk) disable iff (!presetn)
    !(st.en && st.oe) |-> !modulated_out)
    else $error("output pin driven while off");

  a_rdata_upper: assert property (  // RL13
    @(posedge pclk) disable iff (!presetn)
    prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
endmodule // dsmsel_top

// File: rtl/dsmsel_pkg.sv
/*
  Constants shared by the modulator source and carrier select block:
  register offsets, field positions, reset values, source codes, indexes.
  Assumes an APB master on pclk with byte addresses on an 8-bit paddr.
*/
// Notes on behaviour
// RL1: source pin-disable bit stops source peripheral pin; here only while the enable bit is set
// RL2: source code 0 soft bit, 1 pin
// RL3: codes 2-5 PWM units, PWM mode only
// RL4: codes 6-7 comparators, 8-9 SPI, 10 UART
// RL5: source codes 11-15 connect nothing
// RL6: high-carrier pin-disable stops carrier peripheral pin
// RL7: high-carrier polarity bit inverts carrier
// RL8: high sync waits high carrier falling edge
// RL9: no sync switches carriers immediately
// RL10: carrier codes ground, pin1, pin2, reference clock
// RL11: carrier codes 4-7 PWM units, PWM only
// RL12: carrier codes 8-15 connect nothing
// RL13: unused bits ignore writes, read zero
// RL14: selection bits kept across non-power resets; presetn clears them here
// RL15: modulator high mixes high carrier, else low
// RL16: disabled forces ground carriers and soft bit
// RL17: low sync waits low carrier falling edge
// RL18: output polarity bit inverts final output
// RL19: output is mod-selected carrier, sync holds previous
// RL20: pins and peripheral outputs pass two flops
package dsmsel_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SRC  = 8'h04;
  localparam logic [7:0] ADDR_CARH = 8'h08;
  localparam logic [7:0] ADDR_CARL = 8'h0C;

  localparam int CTRL_EN   = 7;
  localparam int CTRL_OE   = 6;
  localparam int CTRL_SLR  = 5;
  localparam int CTRL_OPOL = 4;
  localparam int CTRL_OUT  = 3;
  localparam int CTRL_BIT  = 0;
  localparam int SEL_DIS   = 7;
  localparam int CAR_INV   = 6;
  localparam int CAR_SYNC  = 5;
  localparam int CODE_MSB  = 3;

  localparam logic [7:0] CTRL_RESET = 8'h20;
  localparam logic [7:0] SEL_RESET  = 8'h00;

  localparam logic [3:0] SRC_SOFT = 4'h0;
  localparam logic [3:0] SRC_PIN  = 4'h1;
  localparam logic [3:0] SRC_CCP1 = 4'h2;
  localparam logic [3:0] SRC_CCP4 = 4'h5;
  localparam logic [3:0] SRC_CMP1 = 4'h6;
  localparam logic [3:0] SRC_CMP2 = 4'h7;
  localparam logic [3:0] SRC_SDO1 = 4'h8;
  localparam logic [3:0] SRC_SDO2 = 4'h9;
  localparam logic [3:0] SRC_UART = 4'hA;

  localparam logic [3:0] CAR_GND    = 4'h0;
  localparam logic [3:0] CAR_PIN1   = 4'h1;
  localparam logic [3:0] CAR_PIN2   = 4'h2;
  localparam logic [3:0] CAR_REFCLK = 4'h3;
  localparam logic [3:0] CAR_CCP1   = 4'h4;
  localparam logic [3:0] CAR_CCP4   = 4'h7;

  // Index into the peripheral pin-disable vector
  localparam int P_CCP1   = 0;
  localparam int P_CMP1   = 4;
  localparam int P_SDO1   = 6;
  localparam int P_UART   = 8;
  localparam int P_REFCLK = 9;
  localparam int P_COUNT  = 10;

  // Index into the synchronised input vector
  localparam int S_MODPIN = 0;
  localparam int S_CIN1   = 1;
  localparam int S_CIN2   = 2;
  localparam int S_REFCLK = 3;
  localparam int S_CCP1   = 4;
  localparam int S_CMP1   = 8;
  localparam int S_SDO1   = 10;
  localparam int S_UART   = 12;
  localparam int S_WIDTH  = 13;
endpackage

// File: rtl/dsmsel_sync.sv
/*
  Two-flop synchroniser for a vector of independent levels.
  Assumes each bit is a slow level or a carrier well below pclk/2.
*/
module dsmsel_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } dsmsel_sync_t;

  dsmsel_sync_t st;
  dsmsel_sync_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;   // RL20
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.s2;
endmodule // dsmsel_sync

// File: rtl/dsmsel_carrier_mux.sv
/*
  Carrier source selector with polarity and pin-disable decode.
  Assumes synchronised inputs and PWM-mode flags on the same clock.
*/
module dsmsel_carrier_mux (
  input  wire logic       enable,
  input  wire logic [3:0] code,
  input  wire logic       invert,
  input  wire logic       pin_disable,
  input  wire logic       cin1,
  input  wire logic       cin2,
  input  wire logic       refclk,
  input  wire logic [3:0] ccp,
  input  wire logic [3:0] pwm_mode,
  output logic            carrier,
  output logic [4:0]      periph_dis
);
  logic       raw;
  logic [3:0] unit;

  always_comb begin
    unit       = code - dsmsel_pkg::CAR_CCP1;
    raw        = 1'b0;
    periph_dis = 5'h00;
    if (code == dsmsel_pkg::CAR_GND) begin      // RL10
      raw = 1'b0;
    end else if (code == dsmsel_pkg::CAR_PIN1) begin
      raw = cin1;
    end else if (code == dsmsel_pkg::CAR_PIN2) begin
      raw = cin2;
    end else if (code == dsmsel_pkg::CAR_REFCLK) begin
      raw           = refclk;
      periph_dis[4] = pin_disable;              // RL6
    end else if (code <= dsmsel_pkg::CAR_CCP4) begin
      raw                = ccp[unit[1:0]] & pwm_mode[unit[1:0]];   // RL11
      periph_dis[unit[1:0]] = pin_disable;      // RL6
    end else begin
      raw = 1'b0;                               // RL12
    end
    // Disabled module sees plain ground, polarity ignored
    carrier = enable ? (raw ^ invert) : 1'b0;  // RL7 RL16
  end
endmodule // dsmsel_carrier_mux

// File: tb/dsmsel_periph.sv
/*
  Far-side model: external pins and peripheral outputs feeding the selector.
  Assumes the bench asks for levels in the synchronised-vector order; each
  level reaches its pin LAG clocks later, as a slow peripheral would.
*/
module dsmsel_periph #(
  parameter int LAG = 2
) (
  input  wire logic        pclk,
  input  wire logic [12:0] level_req,
  output logic             modulation_input_pin,
  output logic             carrier_input_pin_1,
  output logic             carrier_input_pin_2,
  output logic             refclk_out,
  output logic [3:0]       ccp_out,
  output logic [1:0]       cmp_out,
  output logic [1:0]       sdo_out,
  output logic             uart_tx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] pipe [LAG];

  always_ff @(posedge pclk) begin
    pipe[0] <= level_req;
    for (int i = 1; i < LAG; i++) begin
      pipe[i] <= pipe[i-1];
    end
  end

  assign modulation_input_pin = pipe[LAG-1][dsmsel_pkg::S_MODPIN];
  assign carrier_input_pin_1  = pipe[LAG-1][dsmsel_pkg::S_CIN1];
  assign carrier_input_pin_2  = pipe[LAG-1][dsmsel_pkg::S_CIN2];
  assign refclk_out           = pipe[LAG-1][dsmsel_pkg::S_REFCLK];
  assign ccp_out              = pipe[LAG-1][dsmsel_pkg::S_CCP1 +: 4];
  assign cmp_out              = pipe[LAG-1][dsmsel_pkg::S_CMP1 +: 2];
  assign sdo_out              = pipe[LAG-1][dsmsel_pkg::S_SDO1 +: 2];
  assign uart_tx              = pipe[LAG-1][dsmsel_pkg::S_UART];
endmodule // dsmsel_periph

// File: tb/dsmsel_top_tb.sv
/*
  Self-checking bench for the modulator source and carrier selector.
  Assumes APB answers may stretch; only the watchdog ends a wait.
*/
module dsmsel_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Two sync flops, one mix flop, partner lag of two, plus margin
  localparam int SETTLE = 8;
  localparam logic [7:0] A_CTRL = dsmsel_pkg::ADDR_CTRL;
  localparam logic [7:0] A_SRC  = dsmsel_pkg::ADDR_SRC;
  localparam logic [7:0] A_CARH = dsmsel_pkg::ADDR_CARH;
  localparam logic [7:0] A_CARL = dsmsel_pkg::ADDR_CARL;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [12:0] level_req;
  logic        mod_pin, cin1, cin2, refclk, uart, mod_out, slew;
  logic [3:0]  ccp, pwm_mode;
  logic [1:0]  cmp, sdo, spi_mode;
  logic [9:0]  pin_dis;
  int          err_total, samples_checked;

  dsmsel_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modulation_input_pin(mod_pin), .carrier_input_pin_1(cin1), .carrier_input_pin_2(cin2),
    .refclk_out(refclk), .ccp_out(ccp), .ccp_pwm_mode(pwm_mode), .cmp_out(cmp), .sdo_out(sdo),
    .spi_mode(spi_mode), .uart_tx(uart), .periph_pin_disable(pin_dis), .modulated_out(mod_out),
    .slew_limit_enable(slew));

  dsmsel_periph #(.LAG(2)) far_side (.pclk(pclk), .level_req(level_req), .modulation_input_pin(mod_pin),
    .carrier_input_pin_1(cin1), .carrier_input_pin_2(cin2), .refclk_out(refclk), .ccp_out(ccp),
    .cmp_out(cmp), .sdo_out(sdo), .uart_tx(uart));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_out(input logic exp, input string what);
    repeat (SETTLE) @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, mod_out}, {31'h0, exp}, what);
  endtask

  task automatic chk_dis(input logic [9:0] exp);
    @(negedge pclk);
    chk({22'h0, pin_dis}, {22'h0, exp}, "pin disable");
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'h1, a, d, rd, e);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    logic        e;
    apb(1'h0, a, 32'h0, rd, e);
    chk(rd, exp, what);
  endtask

  task automatic t_regs;
    logic [31:0] rd;
    logic        e;
    rd_reg(A_CTRL, 32'h20, "control reset");
    chk({31'h0, slew}, 32'h1, "slew reset");
    rd_reg(A_SRC, 32'h0, "source reset");
    rd_reg(A_CARH, 32'h0, "carrier reset");
    wr(A_SRC, 32'hFFFF_FFFF);
    rd_reg(A_SRC, 32'h8F, "source unused bits");
    wr(A_CARH, 32'hFFFF_FFFF);
    rd_reg(A_CARH, 32'hEF, "carrier unused bits");
    apb(1'h1, 8'h10, 32'hFF, rd, e);
    chk({31'h0, e}, 32'h1, "unmapped write error");
    apb(1'h0, 8'h10, 32'h0, rd, e);
    chk(rd, 32'h0, "unmapped read");
  endtask

  // Carrier high is inverted ground, carrier low ground: output follows the source
  task automatic t_sources;
    logic [12:0] v;
    logic        lv;
    wr(A_CARH, 32'h40);
    wr(A_CARL, 32'h0);
    for (int c = 0; c < 16; c++) begin
      wr(A_SRC, 32'(c));
      for (int l = 0; l < 2; l++) begin
        lv = l[0];
        v  = {13{~lv}};
        if (c >= 1 && c <= 10) begin
          v[(c == 1) ? 0 : c + 2] = lv;
        end
        level_req <= v;
        wr(A_CTRL, {24'h0, 7'h60, (c == 0) ? lv : ~lv});
        chk_out((c <= 10) ? lv : 1'h0, "source select");
      end
    end
    @(posedge pclk);
    pwm_mode  <= 4'h0;
    spi_mode  <= 2'h0;
    level_req <= 13'h0410;
    wr(A_SRC, {28'h0, dsmsel_pkg::SRC_CCP1});
    chk_out(1'h0, "pwm unit not in pwm mode");
    wr(A_SRC, {28'h0, dsmsel_pkg::SRC_SDO1});
    chk_out(1'h0, "sdo outside spi mode");
    @(posedge pclk);
    pwm_mode <= 4'hF;
    spi_mode <= 2'h3;
  endtask

  task automatic t_carriers;
    logic [12:0] v;
    logic        lv, ex;
    wr(A_SRC, 32'h0);
    wr(A_CARL, 32'h0);
    wr(A_CTRL, 32'hC1);
    for (int c = 0; c < 16; c++) begin
      for (int k = 0; k < 4; k++) begin
        lv = k[0];
        if (c < 8 || k < 2) begin
          v  = {13{~lv}};
          ex = (c == 0) ? k[1] : 1'h0;
          if (c >= 1 && c <= 7) begin
            v[c] = lv;
            ex   = lv ^ k[1];
          end
          level_req <= v;
          wr(A_CARH, {24'h0, 1'h0, k[1], 2'h0, 4'(c)});
          chk_out(ex, "carrier select");
        end
      end
    end
  endtask

  task automatic t_pin_dis;
    logic [9:0] e;
    for (int c = 0; c < 16; c++) begin
      wr(A_SRC, 32'(128 + c));
      e = 10'h0;
      if (c >= 2 && c <= 10) begin
        e[c-2] = 1'h1;
      end
      chk_dis(e);
      wr(A_SRC, 32'(c));
      chk_dis(10'h0);
    end
    wr(A_SRC, 32'h0);
    for (int c = 0; c < 16; c++) begin
      wr(A_CARH, 32'(128 + c));
      e = 10'h0;
      if (c == 3) begin
        e[dsmsel_pkg::P_REFCLK] = 1'h1;
      end
      if (c >= 4 && c <= 7) begin
        e[c-4] = 1'h1;
      end
      chk_dis(e);
      wr(A_CARH, 32'(c));
      chk_dis(10'h0);
    end
    wr(A_CARL, 32'h84);
    chk_dis(10'h001);
  endtask

  // Carrier held high while the modulator switches away from it
  task automatic t_sync(input logic low_side, input logic sync);
    wr(A_SRC, 32'h0);
    wr(A_CARH, low_side ? 32'h0 : {26'h0, sync, 5'h01});
    wr(A_CARL, low_side ? {26'h0, sync, 5'h02} : 32'h0);
    level_req <= 13'h0006;
    wr(A_CTRL, {24'h0, 7'h60, ~low_side});
    chk_out(1'h1, "before switch");
    wr(A_CTRL, {24'h0, 7'h60, low_side});
    chk_out(sync, "carrier hold");
    level_req <= 13'h0;
    chk_out(1'h0, "after falling edge");
  endtask

  task automatic t_disable;
    wr(A_SRC, 32'h0);
    wr(A_CARL, 32'h0);
    wr(A_CARH, 32'h40);
    wr(A_CTRL, 32'hD1);
    chk_out(1'h0, "output inverted");
    chk({31'h0, slew}, 32'h0, "slew cleared");
    wr(A_CTRL, 32'h51);
    chk_out(1'h0, "disabled output");
    rd_reg(A_CTRL, 32'h59, "status when disabled");
    rd_reg(A_CARH, 32'h40, "selection kept");
    wr(A_CTRL, 32'hC1);
    chk_out(1'h1, "enabled again");
    wr(A_CTRL, 32'h81);
    chk_out(1'h0, "output enable clear");
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    presetn   = 1'h0;
    psel      = 1'h0;
    penable   = 1'h0;
    pwrite    = 1'h0;
    paddr     = 8'h0;
    pwdata    = 32'h0;
    level_req = 13'h0;
    pwm_mode  = 4'hF;
    spi_mode  = 2'h3;
    err_total = 0;
    samples_checked = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_sources;
    t_carriers;
    t_pin_dis;
    t_sync(1'h0, 1'h1);
    t_sync(1'h0, 1'h0);
    t_sync(1'h1, 1'h1);
    t_disable;
    final_report;
  end

  // Whole run needs well under ten thousand cycles
  initial begin
    repeat (30000) @(posedge pclk);
    err_total++;
    final_report;
  end
endmodule // dsmsel_top_tb
